// ==== fcpm_map.svh ====
// widths, field positions and reset values of the pulse modulator
// assumes inclusion by bare name from the package and the design file
`ifndef FCPM_MAP_SVH
`define FCPM_MAP_SVH
`define FCPM_CNT_W        10
`define FCPM_NCH          4
`define FCPM_CTL_INV_LSB  0
`define FCPM_CTL_FLAG_BIT 5
`define FCPM_CTL_LOAD_BIT 6
`define FCPM_CTL_RUN_BIT  7
`define FCPM_CTL_RST      8'h00
`define FCPM_ALL_ZERO     10'h000
`define FCPM_ALL_ONE      10'h3ff
`define FCPM_PERIOD_RST   10'h3ff
`define FCPM_CMP_RST      10'h000
`define FCPM_PH_W         2
`endif

// ==== fcpm_pkg.sv ====
// types shared by the pulse modulator
// assumes fcpm_map.svh on the include path
`include "fcpm_map.svh"
package fcpm_pkg;
  typedef logic [`FCPM_CNT_W-1:0] fcpm_count_t;
  typedef logic [`FCPM_NCH-1:0]   fcpm_chmask_t;
endpackage

// ==== fcpm_modulator.sv ====
// four channel pulse width modulator with one shared 10-bit down counter
// assumes software drives the write strobes one cycle each, synchronous to clk
`timescale 1ns/1ns
`include "fcpm_map.svh"

module fcpm_modulator
  import fcpm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        ctl_wr,
  input  wire logic [7:0]  ctl_wdata,
  input  wire logic        period_high_wr,
  input  wire logic        period_low_wr,
  input  wire logic [7:0]  period_wdata,
  input  wire logic [3:0]  cmp_high_wr,
  input  wire logic [3:0]  cmp_low_wr,
  input  wire logic [7:0]  cmp_wdata,
  input  wire logic        underflow_irq_enable,
  output logic [7:0]       modulator_control_reg,
  output logic [3:0]       channel_output,
  output logic [9:0]       count_value,
  output logic             underflow_irq
);

  fcpm_count_t  count_reg;
  fcpm_count_t  period_hold_reg;
  fcpm_count_t  period_reload_value;
  fcpm_count_t  cmp_hold_reg [`FCPM_NCH];
  fcpm_count_t  cmp_work_reg [`FCPM_NCH];
  fcpm_chmask_t level_reg;
  fcpm_chmask_t invert_reg;
  logic         run_bit;
  logic         load_req_reg;
  logic         underflow_flag;
  logic         underflow;
  logic         load_clear_reg;

  assign underflow = run_bit && (count_reg == `FCPM_ALL_ZERO);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= `FCPM_PERIOD_RST;
    end else if (underflow && load_req_reg) begin
      // new period takes effect in the very interval that the transfer starts
      count_reg <= period_hold_reg;
    end else if (underflow) begin
      count_reg <= period_reload_value;
    end else if (run_bit) begin
      count_reg <= count_reg - 10'h001;
    end
  end

  // high part takes bits 9:8, low part bits 7:0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_hold_reg <= `FCPM_PERIOD_RST;
    end else if (period_high_wr) begin
      period_hold_reg[9:8] <= period_wdata[`FCPM_PH_W-1:0];
    end else if (period_low_wr) begin
      period_hold_reg[7:0] <= period_wdata;
    end
  end

  // transfer only on underflow with load pending
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      period_reload_value <= `FCPM_PERIOD_RST;
    end else if (underflow && load_req_reg) begin
      period_reload_value <= period_hold_reg;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `FCPM_NCH; ch++) begin : g_ch
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cmp_hold_reg[ch] <= `FCPM_CMP_RST;
        end else if (cmp_high_wr[ch]) begin
          cmp_hold_reg[ch][9:8] <= cmp_wdata[`FCPM_PH_W-1:0];
        end else if (cmp_low_wr[ch]) begin
          cmp_hold_reg[ch][7:0] <= cmp_wdata;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cmp_work_reg[ch] <= `FCPM_CMP_RST;
        end else if (underflow && load_req_reg) begin
          cmp_work_reg[ch] <= cmp_hold_reg[ch];
        end
      end

      // level is the non-inverted waveform; frozen while idle
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          level_reg[ch] <= 1'b1;
        end else if (!run_bit) begin
          level_reg[ch] <= level_reg[ch];
        end else if (cmp_work_reg[ch] == `FCPM_ALL_ZERO) begin
          level_reg[ch] <= 1'b1;
        end else if (cmp_work_reg[ch] == `FCPM_ALL_ONE) begin
          level_reg[ch] <= 1'b0;
        end else if (cmp_work_reg[ch] > period_reload_value) begin
          level_reg[ch] <= 1'b0;
        end else if (underflow) begin
          level_reg[ch] <= 1'b1;
        end else if (count_reg == cmp_work_reg[ch]) begin
          level_reg[ch] <= 1'b0;
        end
      end

      always_ff @(posedge clk) begin
        if (sys_rst) begin
          channel_output[ch] <= 1'b1;
        end else if (!run_bit) begin
          channel_output[ch] <= channel_output[ch];
        end else begin
          channel_output[ch] <= level_reg[ch] ^ invert_reg[ch];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run_bit    <= 1'b0;
      invert_reg <= '0;
    end else if (ctl_wr) begin
      run_bit    <= ctl_wdata[`FCPM_CTL_RUN_BIT];
      invert_reg <= ctl_wdata[`FCPM_CTL_INV_LSB +: `FCPM_NCH];
    end
  end

  // a control write replaces the pending request with its load bit, cancelling it when that bit is 0
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_req_reg <= 1'b0;
    end else if (ctl_wr) begin
      load_req_reg <= ctl_wdata[`FCPM_CTL_LOAD_BIT];
    end else if (load_clear_reg) begin
      load_req_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      load_clear_reg <= 1'b0;
    end else begin
      load_clear_reg <= underflow && load_req_reg && !ctl_wr;
    end
  end

  // set wins over the software clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      underflow_flag <= 1'b0;
    end else if (underflow) begin
      underflow_flag <= 1'b1;
    end else if (ctl_wr && !ctl_wdata[`FCPM_CTL_FLAG_BIT]) begin
      underflow_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      underflow_irq <= 1'b0;
    end else begin
      underflow_irq <= underflow_flag && underflow_irq_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      modulator_control_reg <= `FCPM_CTL_RST;
      count_value           <= `FCPM_PERIOD_RST;
    end else begin
      modulator_control_reg <= {run_bit, load_req_reg, underflow_flag, 1'b0, invert_reg};
      count_value           <= count_reg;
    end
  end

  property p_reload;
    @(posedge clk) disable iff (sys_rst)
      underflow |=> count_reg == period_reload_value;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on underflow");

  property p_hold_idle;
    @(posedge clk) disable iff (sys_rst)
      !run_bit && !$past(ctl_wr) |=> $stable(count_reg);
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("counter moved while idle");

  property p_no_xfer_without_uf;
    @(posedge clk) disable iff (sys_rst)
      !underflow |=> $stable(period_reload_value);
  endproperty
  a_no_xfer_without_uf: assert property (p_no_xfer_without_uf) else $error("early transfer");

  sequence s_xfer;
    underflow && load_req_reg && !ctl_wr;
  endsequence
  property p_load_clears;
    @(posedge clk) disable iff (sys_rst)
      s_xfer ##1 !ctl_wr |=> !load_req_reg;
  endproperty
  a_load_clears: assert property (p_load_clears) else $error("load not cleared");

  property p_flag_set;
    @(posedge clk) disable iff (sys_rst)
      underflow |=> underflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_sticky;
    @(posedge clk) disable iff (sys_rst)
      underflow_flag && !ctl_wr |=> underflow_flag;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

  property p_irq;
    @(posedge clk) disable iff (sys_rst)
      underflow_flag && underflow_irq_enable |=> underflow_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_zero_high;
    @(posedge clk) disable iff (sys_rst)
      run_bit && cmp_work_reg[0] == `FCPM_ALL_ZERO |=> level_reg[0];
  endproperty
  a_zero_high: assert property (p_zero_high) else $error("zero compare not high");

  property p_ones_low;
    @(posedge clk) disable iff (sys_rst)
      run_bit && cmp_work_reg[2] == `FCPM_ALL_ONE |=> !level_reg[2];
  endproperty
  a_ones_low: assert property (p_ones_low) else $error("ones compare not low");

  property p_idle_freeze;
    @(posedge clk) disable iff (sys_rst)
      !run_bit |=> $stable(channel_output) && $stable(level_reg);
  endproperty
  a_idle_freeze: assert property (p_idle_freeze) else $error("output moved idle");

  property p_cancel;
    @(posedge clk) disable iff (sys_rst)
      ctl_wr && !ctl_wdata[`FCPM_CTL_LOAD_BIT] |=> !load_req_reg;
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending load not cancelled");

  property p_period_low;
    @(posedge clk) disable iff (sys_rst)
      period_low_wr && !period_high_wr |=> period_hold_reg[7:0] == $past(period_wdata);
  endproperty
  a_period_low: assert property (p_period_low) else $error("period low part lost");

  property p_cmp_xfer;
    @(posedge clk) disable iff (sys_rst)
      underflow && load_req_reg |=> cmp_work_reg[0] == $past(cmp_hold_reg[0]);
  endproperty
  a_cmp_xfer: assert property (p_cmp_xfer) else $error("compare not transferred");

  property p_above_low;
    @(posedge clk) disable iff (sys_rst)
      run_bit && cmp_work_reg[3] > period_reload_value |=> !level_reg[3];
  endproperty
  a_above_low: assert property (p_above_low) else $error("compare above period not low");

  property p_uf_high;
    @(posedge clk) disable iff (sys_rst)
      underflow && cmp_work_reg[0] != `FCPM_ALL_ONE && cmp_work_reg[0] <= period_reload_value
      |=> level_reg[0];
  endproperty
  a_uf_high: assert property (p_uf_high) else $error("underflow did not raise output");

  property p_match_low;
    @(posedge clk) disable iff (sys_rst)
      run_bit && !underflow && cmp_work_reg[0] != `FCPM_ALL_ZERO && count_reg == cmp_work_reg[0]
      |=> !level_reg[0];
  endproperty
  a_match_low: assert property (p_match_low) else $error("compare match did not lower");

  property p_follow;
    @(posedge clk) disable iff (sys_rst)
      run_bit |=> channel_output == $past(level_reg ^ invert_reg);
  endproperty
  a_follow: assert property (p_follow) else $error("output not level with invert");

endmodule // fcpm_modulator

// ==== fcpm_port_pins.sv ====
// port pin model for the four pulse outputs, one latch bit a pin
// assumes port latches reset low and software sets them before use
`timescale 1ns/1ns
module fcpm_port_pins (
  input  wire logic [3:0] port_latch,
  input  wire logic [3:0] channel_output,
  output logic      [3:0] pin_level
);
  // a low latch pulls the pin down whatever the modulator does
  assign pin_level = port_latch & channel_output;
endmodule // fcpm_port_pins

// ==== tb.sv ====
// self-checking bench for the four channel pulse modulator
// assumes fcpm_pkg, fcpm_modulator and fcpm_port_pins compiled first
`timescale 1ns/1ns
module tb;
  import fcpm_pkg::*;
  logic       clk = 1'b0, sys_rst = 1'b1, ctl_wr = 1'b0, irq_en = 1'b1;
  logic       period_high_wr = 1'b0, period_low_wr = 1'b0;
  logic [7:0] ctl_wdata = 8'h00, period_wdata = 8'h00, cmp_wdata = 8'h00;
  logic [3:0] cmp_high_wr = 4'h0, cmp_low_wr = 4'h0, port_latch = 4'h0;
  logic [7:0] ctl_q;
  logic [3:0] ch_q, pins, pin_snap;
  logic [9:0] cnt_q, snap;
  logic       irq_q;
  int         mismatches = 0, checks_done = 0, c;
  logic [15:0] n;
  int         hexp[4] = '{7, 10, 0, 0};
  always #5 clk = ~clk;
  fcpm_modulator i_dut (.clk(clk), .sys_rst(sys_rst), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .period_high_wr(period_high_wr),
    .period_low_wr(period_low_wr), .period_wdata(period_wdata),
    .cmp_high_wr(cmp_high_wr), .cmp_low_wr(cmp_low_wr), .cmp_wdata(cmp_wdata),
    .underflow_irq_enable(irq_en), .modulator_control_reg(ctl_q),
    .channel_output(ch_q), .count_value(cnt_q), .underflow_irq(irq_q));
  fcpm_port_pins i_pins (.port_latch(port_latch), .channel_output(ch_q),
    .pin_level(pins));
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic ctl(input logic [7:0] d);
    tick(1);
    ctl_wdata = d;
    ctl_wr = 1'b1;
    tick(1);
    ctl_wr = 1'b0;
  endtask
  // sel 4 is the period, 0..3 a channel compare; high part goes first
  task automatic wr10(input int sel, input logic [9:0] v);
    tick(1);
    period_wdata = {6'h00, v[9:8]};
    cmp_wdata = {6'h00, v[9:8]};
    if (sel == 4) period_high_wr = 1'b1;
    else cmp_high_wr[sel] = 1'b1;
    tick(1);
    period_high_wr = 1'b0;
    cmp_high_wr = 4'h0;
    period_wdata = v[7:0];
    cmp_wdata = v[7:0];
    if (sel == 4) period_low_wr = 1'b1;
    else cmp_low_wr[sel] = 1'b1;
    tick(1);
    period_low_wr = 1'b0;
    cmp_low_wr = 4'h0;
  endtask
  // control output lags two edges, so skip those before polling
  task automatic wait_load();
    int i;
    tick(2);
    for (i = 0; i < 3000 && ctl_q[6] !== 1'b0; i++) tick(1);
  endtask
  // four-state count so an unknown pin poisons the result
  task automatic hi_time(input int ch, input int len, output logic [15:0] cnt);
    cnt = 16'h0000;
    repeat (len) begin
      tick(1);
      cnt = cnt + pins[ch];
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  initial begin
    tick(12);
    sys_rst = 1'b0;
    chk("outputs", ch_q, 4'hf);
    chk("count", cnt_q, 10'h3ff);
    chk("pins_latch_low", pins, 4'h0);
    port_latch = 4'hf;
    tick(1);
    chk("pins", pins, 4'hf);
    $display("test reset done");
    wr10(4, 10'h009);
    wr10(0, 10'h003);
    wr10(1, 10'h000);
    wr10(2, 10'h3ff);
    wr10(3, 10'h00c);
    tick(5);
    chk("count_idle", cnt_q, 10'h3ff);
    ctl(8'hc0);
    wait_load();
    chk("load_clear", ctl_q[6], 1'b0);
    for (c = 0; c < 4; c++) begin
      hi_time(c, 10, n);
      chk("high_time", n, hexp[c]);
    end
    chk("flag", ctl_q[5], 1'b1);
    chk("irq", irq_q, 1'b1);
    snap = cnt_q;
    tick(10);
    chk("period_repeat", cnt_q, snap);
    $display("test shapes done");
    ctl(8'hc1);
    wait_load();
    hi_time(0, 10, n);
    chk("inverted_high", n, 3);
    ctl(8'h01);
    tick(3);
    pin_snap = pins;
    snap = cnt_q;
    tick(20);
    chk("pins_frozen", pins, pin_snap);
    chk("count_frozen", cnt_q, snap);
    ctl(8'h01);
    tick(3);
    chk("flag_cleared", ctl_q, 8'h01);
    $display("test stop done");
    wr10(4, 10'h005);
    ctl(8'h40);
    tick(30);
    chk("no_run_count", cnt_q, snap);
    chk("no_run_load", ctl_q, 8'h40);
    ctl(8'hc0);
    wait_load();
    hi_time(0, 6, n);
    chk("new_period_high", n, 3);
    irq_en = 1'b0;
    tick(3);
    chk("irq_masked", irq_q, 1'b0);
    $display("test reload done");
    wr10(4, 10'h007);
    // start right after a reload so the cancel lands before the next underflow
    for (c = 0; c < 20 && cnt_q !== 10'h005; c++) tick(1);
    ctl(8'hc0);
    ctl(8'h80);
    tick(10);
    snap = cnt_q;
    tick(6);
    chk("period_kept", cnt_q, snap);
    chk("load_cancel", ctl_q[6], 1'b0);
    $display("test cancel done");
    wr10(0, 10'h000);
    wr10(1, 10'h3ff);
    ctl(8'hc0);
    wait_load();
    ctl(8'h00);
    tick(3);
    chk("known_stop", ch_q, 4'h1);
    chk("known_pins", pins, 4'h1);
    $display("test known stop done");
    end_sim();
  end
endmodule // tb
